// ---- inc/port_mux_regs.svh ----
`ifndef PORT_MUX_REGS_SVH
`define PORT_MUX_REGS_SVH

// byte addresses on the register bus, one aligned 32-bit word each
`define OFS_PORT_A_DATA 8'h00
`define OFS_PORT_A_DIR 8'h04
`define OFS_PORT_A_ALT 8'h08
`define OFS_PORT_B_DATA 8'h10
`define OFS_PORT_B_DIR 8'h14
`define OFS_PORT_B_ALT 8'h18
`define OFS_PORT_B_SEL_LOW 8'h1C
`define OFS_PORT_C_DATA 8'h20
`define OFS_PORT_C_DIR 8'h24
`define OFS_PORT_C_ALT 8'h28
`define OFS_PORT_C_SEL_LOW 8'h2C
`define OFS_PORT_B_SEL_HIGH 8'h30
`define OFS_PORT_C_SEL_HIGH 8'h34
`define OFS_CONFIG 8'h38
`define OFS_PIN_LEVELS 8'h3C

// config register fields
`define CFG_PKG_28_BIT 0
`define CFG_XTAL_BIT 1
`define CFG_EXT_CLK_BIT 2

// reset values; direction bit high means input
`define RST_DATA 8'h00
`define RST_DIR 8'hFF
`define RST_ALT 8'h00
`define RST_SEL 8'h00
`define RST_CFG 1'b0

// pins per port, pins over all three ports
`define PORT_WIDTH 8
`define PIN_COUNT 24

`endif

// ---- inc/port_mux_pkg.sv ----
package port_mux_pkg;

    // what the selected alternate function does with a pin
    typedef enum logic [2:0] {
        fn_none,
        fn_digital_out,
        fn_digital_in,
        fn_analog,
        fn_led,
        fn_shared
    } pin_function_t;

    typedef logic [7:0] port_byte_t;

endpackage

// ---- verilog/pin_cell.sv ----
`timescale 1ns/100ps
`default_nettype none

module pin_cell (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic pin_i,
    input wire logic gpio_data_i,
    input wire logic gpio_input_i,
    input wire logic alt_enable_i,
    input wire port_mux_pkg::pin_function_t function_i,
    input wire logic alt_data_i,
    input wire logic override_i,
    output logic pin_o,
    output logic pin_oe_o,
    output logic level_o
);

    logic sync_first;
    logic next_out;
    logic next_oe;

    always_comb begin
        next_out = 1'b0;
        next_oe = 1'b0;
        if (override_i) begin
            // crystal owns the pin, port logic is cut off
            next_out = 1'b0;
            next_oe = 1'b0;
        end else if (alt_enable_i) begin
            // peripheral owns direction; reserved and analog leave it undriven
            if (function_i == port_mux_pkg::fn_digital_out) begin
                next_out = alt_data_i;
                next_oe = 1'b1;
            end else begin
                next_out = 1'b0;
                next_oe = 1'b0;
            end
        end else begin
            next_out = gpio_data_i;
            next_oe = ~gpio_input_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_first <= 1'b0;
            level_o <= 1'b0;
            pin_o <= 1'b0;
            pin_oe_o <= 1'b0;
        end else if (ce_i) begin
            sync_first <= pin_i;
            level_o <= sync_first;
            pin_o <= next_out;
            pin_oe_o <= next_oe;
        end
    end

endmodule

`default_nettype wire

// ---- verilog/port_alt_function_mux.sv ----
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "port_mux_regs.svh"

// Summary of operation
// - port A alternate enable alone selects each pin's function, fixed except on A0/A6
// - A0/A6 carry timer input or complement output, chosen by timer mode
// - A1 t0 out, A2 driver enable, A3 cts, A4 rx, A5 tx, A7 t1 out
// - port B select-low bit alone picks function; select-high ignored; enable needed
// - B3 select zero gives external clock input, one gives converter channel three
// - B0..B2 at select one give converter inputs zero to two with amplifier
// - converter reference on B5 exists only on 28-pin parts
// - port C select-low bit alone picks function; select-high unused; enable needed
// - C2 at one gives input six, LED drive, or reference on 20-pin only
// - C3 comparator out at zero, LED at one; C4..C7 LED; C0, C1 shared
// - a pin in alternate mode takes direction from its peripheral
// - crystal enable overrides and disables port A pins zero and one
module port_alt_function_mux (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] port_a_in_i,
    output logic [7:0] port_a_out_o,
    output logic [7:0] port_a_oe_o,
    input wire logic [7:0] port_b_in_i,
    output logic [7:0] port_b_out_o,
    output logic [7:0] port_b_oe_o,
    input wire logic [7:0] port_c_in_i,
    output logic [7:0] port_c_out_o,
    output logic [7:0] port_c_oe_o,
    input wire logic timer_zero_input_mode_i,
    input wire logic timer_zero_output_i,
    input wire logic timer_zero_compl_i,
    input wire logic timer_one_input_mode_i,
    input wire logic timer_one_output_i,
    input wire logic timer_one_compl_i,
    input wire logic serial_driver_enable_i,
    input wire logic serial_transmit_data_i,
    input wire logic comparator_output_i,
    input wire logic crystal_enable_i,
    output logic timer_zero_input_o,
    output logic timer_one_input_o,
    output logic serial_clear_to_send_o,
    output logic serial_receive_data_o,
    output logic external_clock_input_o,
    output logic [7:0] analog_connect_b_o,
    output logic [7:0] analog_connect_c_o,
    output logic [7:0] led_drive_select_o,
    output logic vref_connect_o
);

    ////////////////////////////////////////////////////////////////////////////
    // register file

    port_mux_pkg::port_byte_t data_reg [0:2];
    port_mux_pkg::port_byte_t dir_reg [0:2];
    port_mux_pkg::port_byte_t alt_reg [0:2];
    port_mux_pkg::port_byte_t sel_low [0:2];
    port_mux_pkg::port_byte_t sel_high [0:2];
    logic pkg_28;
    port_mux_pkg::port_byte_t next_data [0:2];
    port_mux_pkg::port_byte_t next_dir [0:2];
    port_mux_pkg::port_byte_t next_alt [0:2];
    port_mux_pkg::port_byte_t next_sel_low [0:2];
    port_mux_pkg::port_byte_t next_sel_high [0:2];
    logic next_pkg_28;
    logic [31:0] next_rdata;
    logic next_ack;
    logic bus_req;
    logic bus_wr;

    logic [23:0] level;
    logic [23:0] active;
    logic [23:0] xtal_mask;
    port_mux_pkg::pin_function_t func [0:23];
    logic [23:0] alt_data;
    logic [23:0] pin_out;
    logic [23:0] pin_oe;
    logic [23:0] pin_in;
    logic [23:0] gpio_data;
    logic [23:0] gpio_input;
    logic [23:0] alt_all;
    logic ext_clk_routed;

    // single-cycle answer; the ack gap makes back-to-back strobes two cycles each
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];

    always_comb begin
        for (int p = 0; p < 3; p++) begin
            next_data[p] = data_reg[p];
            next_dir[p] = dir_reg[p];
            next_alt[p] = alt_reg[p];
            next_sel_low[p] = sel_low[p];
            next_sel_high[p] = sel_high[p];
        end
        next_pkg_28 = pkg_28;
        next_rdata = 32'h0000_0000;
        next_ack = bus_req;
        if (bus_wr) begin
            case (wb_adr_i)
                `OFS_PORT_A_DATA: next_data[0] = wb_dat_i[7:0];
                `OFS_PORT_A_DIR: next_dir[0] = wb_dat_i[7:0];
                `OFS_PORT_A_ALT: next_alt[0] = wb_dat_i[7:0];
                `OFS_PORT_B_DATA: next_data[1] = wb_dat_i[7:0];
                `OFS_PORT_B_DIR: next_dir[1] = wb_dat_i[7:0];
                `OFS_PORT_B_ALT: next_alt[1] = wb_dat_i[7:0];
                `OFS_PORT_B_SEL_LOW: next_sel_low[1] = wb_dat_i[7:0];
                `OFS_PORT_B_SEL_HIGH: next_sel_high[1] = wb_dat_i[7:0];
                `OFS_PORT_C_DATA: next_data[2] = wb_dat_i[7:0];
                `OFS_PORT_C_DIR: next_dir[2] = wb_dat_i[7:0];
                `OFS_PORT_C_ALT: next_alt[2] = wb_dat_i[7:0];
                `OFS_PORT_C_SEL_LOW: next_sel_low[2] = wb_dat_i[7:0];
                `OFS_PORT_C_SEL_HIGH: next_sel_high[2] = wb_dat_i[7:0];
                `OFS_CONFIG: next_pkg_28 = wb_dat_i[`CFG_PKG_28_BIT];
                default: next_pkg_28 = pkg_28;
            endcase
        end
        if (bus_req & ~wb_we_i) begin
            case (wb_adr_i)
                `OFS_PORT_A_DATA: next_rdata[7:0] = data_reg[0];
                `OFS_PORT_A_DIR: next_rdata[7:0] = dir_reg[0];
                `OFS_PORT_A_ALT: next_rdata[7:0] = alt_reg[0];
                `OFS_PORT_B_DATA: next_rdata[7:0] = data_reg[1];
                `OFS_PORT_B_DIR: next_rdata[7:0] = dir_reg[1];
                `OFS_PORT_B_ALT: next_rdata[7:0] = alt_reg[1];
                `OFS_PORT_B_SEL_LOW: next_rdata[7:0] = sel_low[1];
                `OFS_PORT_B_SEL_HIGH: next_rdata[7:0] = sel_high[1];
                `OFS_PORT_C_DATA: next_rdata[7:0] = data_reg[2];
                `OFS_PORT_C_DIR: next_rdata[7:0] = dir_reg[2];
                `OFS_PORT_C_ALT: next_rdata[7:0] = alt_reg[2];
                `OFS_PORT_C_SEL_LOW: next_rdata[7:0] = sel_low[2];
                `OFS_PORT_C_SEL_HIGH: next_rdata[7:0] = sel_high[2];
                `OFS_CONFIG: begin
                    next_rdata[`CFG_PKG_28_BIT] = pkg_28;
                    next_rdata[`CFG_XTAL_BIT] = crystal_enable_i;
                    next_rdata[`CFG_EXT_CLK_BIT] = ext_clk_routed;
                end
                `OFS_PIN_LEVELS: next_rdata[23:0] = level;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int p = 0; p < 3; p++) begin
                data_reg[p] <= `RST_DATA;
                dir_reg[p] <= `RST_DIR;
                alt_reg[p] <= `RST_ALT;
                sel_low[p] <= `RST_SEL;
                sel_high[p] <= `RST_SEL;
            end
            pkg_28 <= `RST_CFG;
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            for (int p = 0; p < 3; p++) begin
                data_reg[p] <= next_data[p];
                dir_reg[p] <= next_dir[p];
                alt_reg[p] <= next_alt[p];
                sel_low[p] <= next_sel_low[p];
                sel_high[p] <= next_sel_high[p];
            end
            pkg_28 <= next_pkg_28;
            wb_dat_o <= next_rdata;
            wb_ack_o <= next_ack;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // function decode; port A has no select register, select-high never decoded

    always_comb begin
        for (int k = 0; k < `PIN_COUNT; k++) begin
            func[k] = port_mux_pkg::fn_none;
        end
        alt_data = 24'h00_0000;
        // timer pins flip direction with the timer mode alone
        func[0] = timer_zero_input_mode_i ? port_mux_pkg::fn_digital_in
                                          : port_mux_pkg::fn_digital_out;
        alt_data[0] = timer_zero_compl_i;
        func[1] = port_mux_pkg::fn_digital_out;
        alt_data[1] = timer_zero_output_i;
        func[2] = port_mux_pkg::fn_digital_out;
        alt_data[2] = serial_driver_enable_i;
        func[3] = port_mux_pkg::fn_digital_in;
        func[4] = port_mux_pkg::fn_digital_in;
        func[5] = port_mux_pkg::fn_digital_out;
        alt_data[5] = serial_transmit_data_i;
        func[6] = timer_one_input_mode_i ? port_mux_pkg::fn_digital_in
                                         : port_mux_pkg::fn_digital_out;
        alt_data[6] = timer_one_compl_i;
        func[7] = port_mux_pkg::fn_digital_out;
        alt_data[7] = timer_one_output_i;

        for (int i = 0; i < 3; i++) begin
            if (sel_low[1][i]) begin
                func[8 + i] = port_mux_pkg::fn_analog;
            end
        end
        func[11] = sel_low[1][3] ? port_mux_pkg::fn_analog
                                 : port_mux_pkg::fn_digital_in;
        if (sel_low[1][4]) begin
            func[12] = port_mux_pkg::fn_analog;
        end
        if (sel_low[1][5] & pkg_28) begin
            func[13] = port_mux_pkg::fn_analog;
        end
        // B6 and B7 stay fn_none for both select values

        for (int i = 0; i < 3; i++) begin
            if (sel_low[2][i]) begin
                func[16 + i] = port_mux_pkg::fn_shared;
            end
        end
        if (sel_low[2][3]) begin
            func[19] = port_mux_pkg::fn_led;
        end else begin
            func[19] = port_mux_pkg::fn_digital_out;
            alt_data[19] = comparator_output_i;
        end
        for (int i = 4; i < 8; i++) begin
            if (sel_low[2][i]) begin
                func[16 + i] = port_mux_pkg::fn_led;
            end
        end
    end

    // enable is always required; crystal takes A0/A1 away from everything
    assign alt_all = {alt_reg[2], alt_reg[1], alt_reg[0]};
    assign xtal_mask = {22'h00_0000, crystal_enable_i, crystal_enable_i};
    assign active = alt_all & ~xtal_mask;
    assign ext_clk_routed = active[11] & (func[11] == port_mux_pkg::fn_digital_in);

    ////////////////////////////////////////////////////////////////////////////
    // pins

    assign pin_in = {port_c_in_i, port_b_in_i, port_a_in_i};
    assign gpio_data = {data_reg[2], data_reg[1], data_reg[0]};
    assign gpio_input = {dir_reg[2], dir_reg[1], dir_reg[0]};

    for (genvar g = 0; g < `PIN_COUNT; g++) begin : g_pin
        pin_cell u_cell (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .pin_i(pin_in[g]),
            .gpio_data_i(gpio_data[g]),
            .gpio_input_i(gpio_input[g]),
            .alt_enable_i(alt_all[g]),
            .function_i(func[g]),
            .alt_data_i(alt_data[g]),
            .override_i(xtal_mask[g]),
            .pin_o(pin_out[g]),
            .pin_oe_o(pin_oe[g]),
            .level_o(level[g])
        );
    end

    assign port_a_out_o = pin_out[7:0];
    assign port_b_out_o = pin_out[15:8];
    assign port_c_out_o = pin_out[23:16];
    assign port_a_oe_o = pin_oe[7:0];
    assign port_b_oe_o = pin_oe[15:8];
    assign port_c_oe_o = pin_oe[23:16];

    ////////////////////////////////////////////////////////////////////////////
    // peripheral side; unselected inputs park at their idle level

    logic next_t0_in;
    logic next_t1_in;
    logic next_cts;
    logic next_rx;
    logic next_ext_clk;
    logic [7:0] next_analog_b;
    logic [7:0] next_analog_c;
    logic [7:0] next_led;
    logic next_vref;

    always_comb begin
        next_t0_in = (active[0] & (func[0] == port_mux_pkg::fn_digital_in)) ? level[0]
                                                                            : 1'b0;
        next_t1_in = (active[6] & (func[6] == port_mux_pkg::fn_digital_in)) ? level[6]
                                                                            : 1'b0;
        next_cts = active[3] ? level[3] : 1'b0;
        // receive line idles high so a parked serial port sees no start bit
        next_rx = active[4] ? level[4] : 1'b1;
        next_ext_clk = ext_clk_routed ? level[11] : 1'b0;
        for (int i = 0; i < 8; i++) begin
            next_analog_b[i] = active[8 + i] & (func[8 + i] == port_mux_pkg::fn_analog);
            next_analog_c[i] = active[16 + i] & (func[16 + i] == port_mux_pkg::fn_shared);
            next_led[i] = active[16 + i] & ((func[16 + i] == port_mux_pkg::fn_shared) |
                                            (func[16 + i] == port_mux_pkg::fn_led));
        end
        // reference shows on B5 for 28-pin parts, on C2 for the others
        next_vref = (next_analog_b[5] & pkg_28) | (next_analog_c[2] & ~pkg_28);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_zero_input_o <= 1'b0;
            timer_one_input_o <= 1'b0;
            serial_clear_to_send_o <= 1'b0;
            serial_receive_data_o <= 1'b1;
            external_clock_input_o <= 1'b0;
            analog_connect_b_o <= 8'h00;
            analog_connect_c_o <= 8'h00;
            led_drive_select_o <= 8'h00;
            vref_connect_o <= 1'b0;
        end else if (ce_i) begin
            timer_zero_input_o <= next_t0_in;
            timer_one_input_o <= next_t1_in;
            serial_clear_to_send_o <= next_cts;
            serial_receive_data_o <= next_rx;
            external_clock_input_o <= next_ext_clk;
            analog_connect_b_o <= next_analog_b;
            analog_connect_c_o <= next_analog_c;
            led_drive_select_o <= next_led;
            vref_connect_o <= next_vref;
        end
    end

endmodule

`default_nettype wire

// ---- test/port_mux_props.sv ----
`timescale 1ns/100ps
`default_nettype none

module port_mux_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [7:0] port_a_oe_o,
    input wire logic [7:0] port_b_oe_o,
    input wire logic [7:0] port_c_oe_o,
    input wire logic crystal_enable_i,
    input wire logic serial_receive_data_o,
    input wire logic [7:0] analog_connect_b_o,
    input wire logic [7:0] analog_connect_c_o,
    input wire logic [7:0] led_drive_select_o,
    input wire logic vref_connect_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////////
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
        else $error("bus request not answered after one cycle");
    a_ack_single: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("bus ack held longer than one cycle");
    a_write_data: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not cleared on write ack");
    // state is checked one edge after release, when the reset edge has landed
    a_reset_state: assert property ($fell(rst_i) |-> port_a_oe_o == 8'h00
        && port_b_oe_o == 8'h00 && serial_receive_data_o && !wb_ack_o)
        else $error("pins or bus not quiet after reset");
    a_crystal_hold: assert property (crystal_enable_i |=> port_a_oe_o[1:0] == 2'b00)
        else $error("crystal pins driven while crystal enabled");
    a_b_reserved: assert property (analog_connect_b_o[7:6] == 2'b00)
        else $error("analog switch on a reserved port b pin");
    a_c_analog: assert property (analog_connect_c_o[7:3] == 5'h00)
        else $error("analog switch on a port c led only pin");
    // switch select and pin enable are registered on the same edge: no slack
    a_analog_quiet: assert property (
        (port_b_oe_o & analog_connect_b_o) == 8'h00)
        else $error("analog port b pin driven digitally");
    a_led_quiet: assert property (
        (port_c_oe_o & led_drive_select_o) == 8'h00)
        else $error("led port c pin driven digitally");
    a_vref_source: assert property (vref_connect_o && $stable(vref_connect_o) |->
        analog_connect_b_o[5] || analog_connect_c_o[2])
        else $error("reference connected with no reference pin selected");

    c_crystal: cover property (crystal_enable_i);
    c_vref: cover property (vref_connect_o);
    c_led: cover property (led_drive_select_o == 8'hFF);
endmodule

bind port_alt_function_mux port_mux_props u_props (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o,
    .port_a_oe_o, .port_b_oe_o, .port_c_oe_o, .crystal_enable_i, .serial_receive_data_o,
    .analog_connect_b_o, .analog_connect_c_o, .led_drive_select_o, .vref_connect_o
);

`default_nettype wire

// ---- test/periph_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// [7] crystal, [6] t1 mode, [5] t0 mode, [4] comparator, [3] tx, [2] drv en,
// [1] t1 out, [0] t0 out, [9:8] complements of [1:0]
module periph_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] set_i,
    output logic [9:0] periph_o
);
    logic [7:0] state;
    logic [7:0] next_state;

    always_comb begin
        next_state = rst_i ? 8'h00 : set_i;
    end

    always_ff @(posedge clk_i) begin
        state <= next_state;
    end

    // mode bits belong to the timers, never to the port settings
    assign periph_o[7:0] = state;
    assign periph_o[9:8] = ~state[1:0];
endmodule

`default_nettype wire

// ---- test/port_alt_function_mux_test.sv ----
`timescale 1ns/100ps
`default_nettype none

module port_alt_function_mux_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [7:0] port_a_in_i = 8'h00;
    logic [7:0] port_b_in_i = 8'h00;
    logic [7:0] port_c_in_i = 8'h00;
    logic [7:0] setv = 8'h00;
    logic [9:0] pv;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [7:0] port_a_out_o, port_a_oe_o, port_b_out_o, port_b_oe_o;
    logic [7:0] port_c_out_o, port_c_oe_o;
    logic timer_zero_input_o, timer_one_input_o, serial_clear_to_send_o, serial_receive_data_o;
    logic external_clock_input_o, vref_connect_o;
    logic [7:0] analog_connect_b_o, analog_connect_c_o, led_drive_select_o;
    logic [31:0] q;
    logic [31:0] a_view;
    logic [31:0] b_view;
    logic [31:0] c_view;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] a_set [2] = '{8'h45, 8'h2A};
    logic [7:0] a_pin [2] = '{8'h48, 8'h11};
    logic [19:0] a_exp [2] = '{20'hA_7066, 20'hE_6A09};
    logic [7:0] b_adr [6] = '{8'h30, 8'h1C, 8'h38, 8'h18, 8'h18, 8'h1C};
    logic [7:0] b_dat [6] = '{8'hFF, 8'h3F, 8'h01, 8'h00, 8'hFF, 8'hC0};
    logic [17:0] b_exp [6] = '{18'h0_0001, 18'h0_007C, 18'h0_00FE, 18'h3_FC00, 18'h0_00FE,
        18'h0_0001};

    always #5 clk_i = ~clk_i;

    assign a_view = {12'h000, port_a_oe_o, port_a_out_o, timer_zero_input_o,
        timer_one_input_o, serial_clear_to_send_o, serial_receive_data_o};
    assign b_view = {14'h0000, port_b_oe_o, analog_connect_b_o, vref_connect_o,
        external_clock_input_o};
    assign c_view = {4'h0, port_c_oe_o, port_c_out_o, led_drive_select_o,
        analog_connect_c_o[2:0], vref_connect_o};

    periph_model model (.clk_i, .rst_i, .set_i(setv), .periph_o(pv));

    port_alt_function_mux dut (
        .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .port_a_in_i, .port_a_out_o, .port_a_oe_o, .port_b_in_i, .port_b_out_o,
        .port_b_oe_o, .port_c_in_i, .port_c_out_o, .port_c_oe_o,
        .timer_zero_input_mode_i(pv[5]), .timer_zero_output_i(pv[0]),
        .timer_zero_compl_i(pv[8]), .timer_one_input_mode_i(pv[6]),
        .timer_one_output_i(pv[1]), .timer_one_compl_i(pv[9]),
        .serial_driver_enable_i(pv[2]), .serial_transmit_data_i(pv[3]),
        .comparator_output_i(pv[4]), .crystal_enable_i(pv[7]),
        .timer_zero_input_o, .timer_one_input_o, .serial_clear_to_send_o,
        .serial_receive_data_o, .external_clock_input_o, .analog_connect_b_o,
        .analog_connect_c_o, .led_drive_select_o, .vref_connect_o
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // longest path is pin input to peripheral output, three edges
    task automatic settle;
        repeat (4) @(posedge clk_i);
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            $display("CHECK FAILED bus ack expected 1 seen %b", wb_ack_o);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, {24'h00_0000, d});
        settle();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0000_0000);
        chk(nm, e, q);
    endtask

    task automatic pins(input logic [7:0] s, input logic [7:0] a, input logic [7:0] b,
        input logic [7:0] c);
        @(posedge clk_i);
        setv <= s;
        port_a_in_i <= a;
        port_b_in_i <= b;
        port_c_in_i <= c;
        settle();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            stop_test();
        end
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h04, 32'h0000_00FF, "port a direction");
        rd(8'h18, 32'h0000_0000, "port b enable");
        rd(8'h38, 32'h0000_0000, "config");
        chk("idle pins", 32'h0000_0001,
            {port_a_oe_o, port_b_oe_o, port_c_oe_o, serial_receive_data_o});
        wr(8'h08, 8'hFF);
        for (int i = 0; i < 2; i++) begin
            pins(a_set[i], a_pin[i], 8'h00, 8'h00);
            chk("port a functions", {12'h000, a_exp[i]}, a_view);
        end
        pins(8'h85, 8'h00, 8'h00, 8'h00);
        chk("crystal override", 32'h0000_00E4, {24'h00_0000, port_a_oe_o});
        rd(8'h38, 32'h0000_0002, "crystal status");
        pins(8'h00, 8'h00, 8'h00, 8'h00);
        wr(8'h08, 8'h00);
        wr(8'h04, 8'h00);
        wr(8'h00, 8'h5A);
        chk("port a gpio", 32'h0000_FF5A, {16'h0000, port_a_oe_o, port_a_out_o});
        wr(8'h14, 8'h00);
        wr(8'h10, 8'hFF);
        // clock pin routed first; only then may the oscillator be switched over
        wr(8'h18, 8'hFF);
        pins(8'h00, 8'h11, 8'h08, 8'h00);
        chk("port b clock", 32'h0000_0001, b_view);
        rd(8'h38, 32'h0000_0004, "clock routed");
        rd(8'h3C, 32'h0000_0811, "pin levels");
        // enable low must freeze synchronisers and peripheral side alike
        @(posedge clk_i);
        ce_i <= 1'b0;
        port_b_in_i <= 8'h00;
        settle();
        chk("frozen clock input", 32'h0000_0001, {31'h0000_0000, external_clock_input_o});
        ce_i <= 1'b1;
        pins(8'h00, 8'h11, 8'h08, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(b_adr[i], b_dat[i]);
            chk("b select", {14'h0000, b_exp[i]}, b_view);
            if (i == 3) begin
                chk("port b gpio", 32'h0000_00FF, {24'h00_0000, port_b_out_o});
            end
        end
        wr(8'h38, 8'h00);
        wr(8'h24, 8'h00);
        wr(8'h20, 8'hFF);
        wr(8'h28, 8'hFF);
        pins(8'h10, 8'h11, 8'h08, 8'h00);
        chk("comparator high", 32'h0080_8000, c_view);
        wr(8'h34, 8'hFF);
        pins(8'h00, 8'h11, 8'h08, 8'h00);
        chk("comparator low", 32'h0080_0000, c_view);
        wr(8'h2C, 8'hFF);
        chk("port c led", 32'h0000_0FFF, c_view);
        wr(8'h38, 8'h01);
        chk("port c 28 pin", 32'h0000_0FFE, c_view);
        wr(8'h0C, 8'hFF);
        rd(8'h0C, 32'h0000_0000, "port a select");
        rd(8'h40, 32'h0000_0000, "unmapped");
        stop_test();
    end
endmodule

`default_nettype wire
